// ### common/mps_pkg.sv
// Shared constants for the module power sequencing host controller.
// Assumes a 50 MHz system clock and a byte-wide paged register map on the module.
package mps_pkg;
   // Clock rate and the host wait after releasing module reset
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned INIT_WAIT_S = 2;
   localparam int unsigned INIT_WAIT_CYC = INIT_WAIT_S * CLK_HZ;
   localparam int unsigned TMR_W = 27;

   // Register pages
   localparam logic [7:0] PAGE_LOWER = 8'h00;
   localparam logic [7:0] PAGE_PATH = 8'h10;
   localparam logic [7:0] PAGE_STATUS = 8'h11;

   // Register offsets
   localparam logic [7:0] OFS_LATCHED_FLAGS = 8'h08;
   localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h1a;
   localparam logic [7:0] OFS_ADV_APP = 8'h56;
   localparam logic [7:0] OFS_ADV_TIMEOUT = 8'h9c;
   localparam logic [7:0] OFS_PATH_POWER = 8'h80;
   localparam logic [7:0] OFS_TX_DISABLE = 8'h82;
   localparam logic [7:0] OFS_APPLY_SET0 = 8'h8f;
   localparam logic [7:0] OFS_APP_SELECT = 8'h91;
   localparam logic [7:0] OFS_CFG_ERROR = 8'hca;

   // Field positions and values
   localparam int unsigned FORCE_LP_BIT = 4;
   localparam int unsigned APP_CODE_LSB = 4;
   localparam logic [7:0] ALL_LANES = 8'hff;
   localparam logic [7:0] NO_LANES = 8'h00;
   localparam logic [7:0] CFG_ERR_NONE = 8'h00;
   localparam logic [7:0] FORCE_LP_SET = 8'h01 << FORCE_LP_BIT;
   localparam logic [7:0] GLOBAL_RUN = 8'h00;

   // Controller states
   typedef enum logic [4:0] {
      ST_HOLD, ST_WAIT_INIT, ST_ACK, ST_RD_ADV, ST_RD_TMO, ST_IDLE_LOW,
      ST_WR_GLOBAL, ST_WR_APPLICATION_CODE, ST_WR_APPLY, ST_RD_CFGERR, ST_WR_TXDIS,
      ST_WR_PWRUP, ST_WAIT_EVT, ST_WR_TXEN, ST_ACTIVE, ST_WR_PWRDN,
      ST_PATHS_OFF, ST_WR_FORCE
   } mps_state_t;
endpackage

// ### rtl/mps_wait_timer.sv
// One-shot down counter used for the host's bounded waits.
// Assumes loadVal is at least one when start pulses.
`timescale 1ns/1ps
`default_nettype none
module mps_wait_timer import mps_pkg::*; #(
   parameter int unsigned W = TMR_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic [W-1:0] loadVal,
   // Status
   output logic expired
);
   logic [W-1:0] count_reg, count_next;
   logic run_reg, run_next;
   logic exp_reg, exp_next;

   // Restart on start, count down while running
   always_comb begin
      count_next = count_reg;
      run_next = run_reg;
      exp_next = exp_reg;
      if (start) begin
         count_next = loadVal;
         run_next = 1'b1;
         exp_next = 1'b0;
      end else if (run_reg) begin
         count_next = count_reg - 1'b1;
         if (count_reg <= W'(1)) begin
            run_next = 1'b0;
            exp_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= '0;
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         run_reg <= run_next;
         exp_reg <= exp_next;
      end
   end

   assign expired = exp_reg;
endmodule
`default_nettype wire

// ### rtl/mps_reg_master.sv
// Single register access engine toward the module management port.
// Assumes the module answers each held request with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module mps_reg_master import mps_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Command from the sequencer
   input wire logic start,
   input wire logic write,
   input wire logic [7:0] page,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata,
   // Management port
   output logic mgmtReq,
   output logic mgmtWrite,
   output logic [7:0] mgmtPage,
   output logic [7:0] mgmtAddr,
   output logic [7:0] mgmtWdata,
   input wire logic mgmtAck,
   input wire logic [7:0] mgmtRdata
);
   logic req_reg, req_next, wr_reg, wr_next, done_reg, done_next;
   logic [7:0] page_reg, page_next, addr_reg, addr_next;
   logic [7:0] wd_reg, wd_next, rd_reg, rd_next;

   // Hold the request until acknowledged; start ignored while busy
   always_comb begin
      req_next = req_reg;
      wr_next = wr_reg;
      page_next = page_reg;
      addr_next = addr_reg;
      wd_next = wd_reg;
      rd_next = rd_reg;
      done_next = 1'b0;
      if (req_reg) begin
         if (mgmtAck) begin
            req_next = 1'b0;
            done_next = 1'b1;
            if (!wr_reg) rd_next = mgmtRdata;
         end
      end else if (start) begin
         req_next = 1'b1;
         wr_next = write;
         page_next = page;
         addr_next = addr;
         wd_next = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_reg <= 1'b0;
         wr_reg <= 1'b0;
         done_reg <= 1'b0;
         page_reg <= 8'h00;
         addr_reg <= 8'h00;
         wd_reg <= 8'h00;
         rd_reg <= 8'h00;
      end else begin
         req_reg <= req_next;
         wr_reg <= wr_next;
         done_reg <= done_next;
         page_reg <= page_next;
         addr_reg <= addr_next;
         wd_reg <= wd_next;
         rd_reg <= rd_next;
      end
   end

   assign mgmtReq = req_reg;
   assign mgmtWrite = wr_reg;
   assign mgmtPage = page_reg;
   assign mgmtAddr = addr_reg;
   assign mgmtWdata = wd_reg;
   assign done = done_reg;
   assign rdata = rd_reg;
endmodule
`default_nettype wire

// ### rtl/mps_host_seq.sv
// Host-side sequencer that brings a pluggable module up and down.
// Assumes a module with software init, one management port and an
// active-low interrupt pin; user commands are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module mps_host_seq import mps_pkg::*; #(
   parameter int unsigned INIT_WAIT = INIT_WAIT_CYC,
   parameter int unsigned EVT_WAIT = INIT_WAIT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // User commands
   input wire logic enable,
   input wire logic cmdPowerUp,
   input wire logic cmdPowerDown,
   input wire logic cmdLowPower,
   input wire logic [3:0] appCode,
   input wire logic [7:0] laneMask,
   // User status
   output logic busy,
   output logic pathsActive,
   output logic lowPower,
   output logic cfgError,
   output logic timedOut,
   output logic [7:0] advApps,
   output logic [7:0] advTimeout,
   output logic [7:0] lastFlags,
   output logic [7:0] hostTxLanesEn,
   // Module pins
   output logic module_reset_n,
   output logic init_select,
   input wire logic interrupt_n,
   input wire logic presence_n,
   // Management port
   output logic mgmtReq,
   output logic mgmtWrite,
   output logic [7:0] mgmtPage,
   output logic [7:0] mgmtAddr,
   output logic [7:0] mgmtWdata,
   input wire logic mgmtAck,
   input wire logic [7:0] mgmtRdata
);
   mps_state_t state_reg, state_next, after_reg, after_next;
   logic issued_reg, issued_next;
   logic rst_out_reg, rst_out_next;
   logic busy_reg, busy_next, act_reg, act_next, low_reg, low_next;
   logic cfgErr_reg, cfgErr_next, tmo_reg, tmo_next;
   logic [7:0] adv_reg, adv_next, advTmo_reg, advTmo_next;
   logic [7:0] flags_reg, flags_next, txEn_reg, txEn_next;
   logic [3:0] app_reg, app_next;
   logic [7:0] mask_reg, mask_next;
   logic isAccess, accWrite, accStart, accDone;
   logic [7:0] accPage, accAddr, accData, accRdata;
   logic tmrStart, tmrExpired;
   logic [TMR_W-1:0] tmrLoad;

   // Register access engine
   mps_reg_master u_master (
      .clk(clk),
      .rst_n(rst_n),
      .start(accStart),
      .write(accWrite),
      .page(accPage),
      .addr(accAddr),
      .wdata(accData),
      .done(accDone),
      .rdata(accRdata),
      .mgmtReq(mgmtReq),
      .mgmtWrite(mgmtWrite),
      .mgmtPage(mgmtPage),
      .mgmtAddr(mgmtAddr),
      .mgmtWdata(mgmtWdata),
      .mgmtAck(mgmtAck),
      .mgmtRdata(mgmtRdata)
   );

   // Bounded wait for the module interrupt
   mps_wait_timer #(.W(TMR_W)) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .start(tmrStart),
      .loadVal(tmrLoad),
      .expired(tmrExpired)
   );

   // Access decode per state
   always_comb begin
      isAccess = 1'b1;
      accWrite = 1'b1;
      accPage = PAGE_PATH;
      accAddr = OFS_PATH_POWER;
      accData = 8'h00;
      unique case (state_reg)
         ST_ACK: begin
            accWrite = 1'b0;
            accPage = PAGE_LOWER;
            accAddr = OFS_LATCHED_FLAGS;
         end
         ST_RD_ADV: begin
            accWrite = 1'b0;
            accPage = PAGE_LOWER;
            accAddr = OFS_ADV_APP;
         end
         ST_RD_TMO: begin
            accWrite = 1'b0;
            accPage = PAGE_LOWER;
            accAddr = OFS_ADV_TIMEOUT;
         end
         ST_WR_GLOBAL: begin
            accPage = PAGE_LOWER;
            accAddr = OFS_GLOBAL_CTRL;
            accData = GLOBAL_RUN;
         end
         ST_WR_APPLICATION_CODE: begin
            accAddr = OFS_APP_SELECT;
            accData = {app_reg, 4'h0};
         end
         ST_WR_APPLY: begin
            accAddr = OFS_APPLY_SET0;
            accData = mask_reg;
         end
         ST_RD_CFGERR: begin
            accWrite = 1'b0;
            accPage = PAGE_STATUS;
            accAddr = OFS_CFG_ERROR;
         end
         ST_WR_TXDIS: begin
            accAddr = OFS_TX_DISABLE;
            accData = ALL_LANES;
         end
         ST_WR_PWRUP: accData = mask_reg;
         ST_WR_TXEN: begin
            accAddr = OFS_TX_DISABLE;
            accData = ~mask_reg;
         end
         ST_WR_PWRDN: accData = NO_LANES;
         ST_WR_FORCE: begin
            accPage = PAGE_LOWER;
            accAddr = OFS_GLOBAL_CTRL;
            accData = FORCE_LP_SET;
         end
         default: isAccess = 1'b0;
      endcase
   end

   assign accStart = isAccess && !issued_reg;

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      after_next = after_reg;
      issued_next = issued_reg;
      rst_out_next = rst_out_reg;
      cfgErr_next = cfgErr_reg;
      tmo_next = tmo_reg;
      adv_next = adv_reg;
      advTmo_next = advTmo_reg;
      flags_next = flags_reg;
      txEn_next = txEn_reg;
      app_next = app_reg;
      mask_next = mask_reg;
      tmrStart = 1'b0;
      tmrLoad = TMR_W'(EVT_WAIT);
      if (isAccess) begin
         issued_next = 1'b1;
         if (accDone) issued_next = 1'b0;
      end
      unique case (state_reg)
         ST_HOLD: begin
            rst_out_next = 1'b0;
            if (!presence_n && enable) begin
               rst_out_next = 1'b1;
               tmo_next = 1'b0;
               tmrStart = 1'b1;
               tmrLoad = TMR_W'(INIT_WAIT);
               after_next = ST_RD_ADV;
               state_next = ST_WAIT_INIT;
            end
         end
         ST_WAIT_INIT, ST_WAIT_EVT: begin
            // Interrupt low means a latched state change is waiting
            if (!interrupt_n) begin
               state_next = ST_ACK;
            end else if (tmrExpired && !tmrStart) begin
               tmo_next = 1'b1;
               state_next = ST_ACK;
            end
         end
         ST_ACK: if (accDone) begin
            flags_next = accRdata;
            state_next = after_reg;
         end
         ST_RD_ADV: if (accDone) begin
            adv_next = accRdata;
            state_next = ST_RD_TMO;
         end
         ST_RD_TMO: if (accDone) begin
            advTmo_next = accRdata;
            state_next = ST_IDLE_LOW;
         end
         ST_IDLE_LOW, ST_PATHS_OFF: begin
            if (cmdPowerUp) begin
               app_next = appCode;
               mask_next = laneMask;
               cfgErr_next = 1'b0;
               state_next = (state_reg == ST_IDLE_LOW) ? ST_WR_GLOBAL : ST_WR_APPLICATION_CODE;
            end else if (cmdLowPower && state_reg == ST_PATHS_OFF) begin
               state_next = ST_WR_FORCE;
            end
         end
         ST_WR_GLOBAL: if (accDone) state_next = ST_WR_APPLICATION_CODE;
         ST_WR_APPLICATION_CODE: if (accDone) state_next = ST_WR_APPLY;
         ST_WR_APPLY: if (accDone) state_next = ST_RD_CFGERR;
         ST_RD_CFGERR: if (accDone) begin
            // Any lane error code aborts the power-up
            if (accRdata != CFG_ERR_NONE) begin
               cfgErr_next = 1'b1;
               state_next = ST_IDLE_LOW;
            end else begin
               state_next = ST_WR_TXDIS;
            end
         end
         ST_WR_TXDIS: if (accDone) begin
            txEn_next = mask_reg;
            state_next = ST_WR_PWRUP;
         end
         ST_WR_PWRUP, ST_WR_PWRDN, ST_WR_FORCE: if (accDone) begin
            tmrStart = 1'b1;
            tmo_next = 1'b0;
            state_next = ST_WAIT_EVT;
            unique case (state_reg)
               ST_WR_PWRUP: after_next = ST_WR_TXEN;
               ST_WR_PWRDN: after_next = ST_PATHS_OFF;
               default: after_next = ST_IDLE_LOW;
            endcase
         end
         ST_WR_TXEN: if (accDone) state_next = ST_ACTIVE;
         ST_ACTIVE: begin
            if (cmdPowerDown) state_next = ST_WR_PWRDN;
            else if (cmdLowPower) state_next = ST_WR_FORCE;
         end
         default: state_next = ST_HOLD;
      endcase
      // Paths off: stop feeding the module
      if (state_next == ST_PATHS_OFF || state_next == ST_IDLE_LOW) txEn_next = NO_LANES;
      // Unplug or disable returns to hold, clears the host lanes and holds reset
      if (presence_n || !enable) begin
         state_next = ST_HOLD;
         rst_out_next = 1'b0;
         issued_next = 1'b0;
         txEn_next = NO_LANES;
      end
   end

   // Status flags follow the next state
   always_comb begin
      low_next = (state_next == ST_IDLE_LOW);
      act_next = (state_next == ST_ACTIVE);
      busy_next = !(state_next inside {ST_HOLD, ST_IDLE_LOW, ST_ACTIVE, ST_PATHS_OFF});
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_HOLD;
         after_reg <= ST_HOLD;
         issued_reg <= 1'b0;
         rst_out_reg <= 1'b0;
         busy_reg <= 1'b0;
         act_reg <= 1'b0;
         low_reg <= 1'b0;
         cfgErr_reg <= 1'b0;
         tmo_reg <= 1'b0;
         adv_reg <= 8'h00;
         advTmo_reg <= 8'h00;
         flags_reg <= 8'h00;
         txEn_reg <= 8'h00;
         app_reg <= 4'h0;
         mask_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         issued_reg <= issued_next;
         rst_out_reg <= rst_out_next;
         busy_reg <= busy_next;
         act_reg <= act_next;
         low_reg <= low_next;
         cfgErr_reg <= cfgErr_next;
         tmo_reg <= tmo_next;
         adv_reg <= adv_next;
         advTmo_reg <= advTmo_next;
         flags_reg <= flags_next;
         txEn_reg <= txEn_next;
         app_reg <= app_next;
         mask_reg <= mask_next;
      end
   end

   // Outputs straight from flops, except init_select tied high
   assign module_reset_n = rst_out_reg;
   assign init_select = 1'b1; // Software init mode, constant
   assign busy = busy_reg;
   assign pathsActive = act_reg;
   assign lowPower = low_reg;
   assign cfgError = cfgErr_reg;
   assign timedOut = tmo_reg;
   assign advApps = adv_reg;
   assign advTimeout = advTmo_reg;
   assign lastFlags = flags_reg;
   assign hostTxLanesEn = txEn_reg;
endmodule
`default_nettype wire

// ### sim/mps_host_seq_asserts.sv
// Concurrent checks on the sequencer pins and management port.
// Assumes it is bound into mps_host_seq and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mps_host_seq_asserts import mps_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // User side
   input wire logic enable,
   input wire logic pathsActive,
   input wire logic lowPower,
   input wire logic cfgError,
   input wire logic timedOut,
   input wire logic [7:0] hostTxLanesEn,
   // Module pins
   input wire logic module_reset_n,
   input wire logic init_select,
   input wire logic interrupt_n,
   input wire logic presence_n,
   // Management port
   input wire logic mgmtReq,
   input wire logic mgmtWrite,
   input wire logic [7:0] mgmtPage,
   input wire logic [7:0] mgmtAddr,
   input wire logic [7:0] mgmtWdata,
   input wire logic mgmtAck
);
   logic txAllOff;
   logic wrPower;
   logic wrTxDis;
   logic wrGlobal;
   // Decoded write requests
   assign wrPower = mgmtReq && mgmtWrite && mgmtPage == PAGE_PATH && mgmtAddr == OFS_PATH_POWER;
   assign wrTxDis = mgmtReq && mgmtWrite && mgmtPage == PAGE_PATH && mgmtAddr == OFS_TX_DISABLE;
   assign wrGlobal = mgmtReq && mgmtWrite && mgmtPage == PAGE_LOWER && mgmtAddr == OFS_GLOBAL_CTRL;
   // Remembers whether all media lanes were last disabled
   always_ff @(posedge clk) begin
      if (!rst_n)
         txAllOff <= 1'b0;
      else if (wrTxDis && mgmtAck)
         txAllOff <= (mgmtWdata == ALL_LANES);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_hold_when_absent: assert property ((presence_n || !enable) |-> ##[1:2]
      (!module_reset_n && hostTxLanesEn == NO_LANES)) else $error("module not held in reset");
   a_sw_init_mode: assert property (init_select)
      else $error("init select not high");
   a_req_held: assert property (mgmtReq && !mgmtAck |=> mgmtReq &&
      $stable({mgmtWrite, mgmtPage, mgmtAddr, mgmtWdata})) else $error("request changed");
   a_req_gap: assert property (mgmtReq && mgmtAck |=> !mgmtReq [*2])
      else $error("request too soon after ack");
   a_flag_read: assert property ($fell(interrupt_n) |-> ##[1:3] (mgmtReq && !mgmtWrite &&
      mgmtPage == PAGE_LOWER && mgmtAddr == OFS_LATCHED_FLAGS)) else $error("no flag read");
   a_txdis_first: assert property (wrPower && mgmtWdata != NO_LANES |-> txAllOff)
      else $error("power request with media lanes on");
   a_host_tx_ready: assert property (wrPower && mgmtWdata != NO_LANES |->
      hostTxLanesEn == mgmtWdata) else $error("host lanes not enabled");
   a_media_enable: assert property (wrTxDis && mgmtWdata != ALL_LANES |->
      mgmtWdata == ~hostTxLanesEn && interrupt_n) else $error("bad media enable");
   a_force_code: assert property (wrGlobal |->
      mgmtWdata == GLOBAL_RUN || mgmtWdata == FORCE_LP_SET) else $error("bad global value");
   a_modes_apart: assert property (pathsActive |-> !lowPower)
      else $error("active and low power together");
   // Main scenarios
   c_active: cover property ($rose(pathsActive));
   c_cfg_error: cover property ($rose(cfgError));
   c_timeout: cover property ($rose(timedOut));
endmodule
`default_nettype wire

// ### sim/mps_module_model.sv
// Behavioural module: registers, state-change flag and interrupt pin.
// Assumes the host holds each request until the one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module mps_module_model import mps_pkg::*; #(
   parameter logic [7:0] ADV_APP = 8'h5a,
   parameter logic [7:0] ADV_TMO = 8'h3c,
   parameter logic [3:0] BAD_APP = 4'hf
) (
   // Pins
   input wire logic clk,
   input wire logic module_reset_n,
   output logic interrupt_n,
   // Scenario controls
   input wire logic slow,
   input wire logic mute,
   // Management port
   input wire logic mgmtReq,
   input wire logic mgmtWrite,
   input wire logic [7:0] mgmtPage,
   input wire logic [7:0] mgmtAddr,
   input wire logic [7:0] mgmtWdata,
   output logic mgmtAck,
   output logic [7:0] mgmtRdata
);
   logic [7:0] flags, appSel, cfgErr;
   logic [5:0] evtCnt;
   logic [1:0] dly;
   logic done;
   // Interrupt low while any flag is latched
   assign interrupt_n = ~|flags;
   // Event timer, register file and access handshake
   always_ff @(posedge clk) begin
      mgmtAck <= 1'b0;
      mgmtRdata <= ~mgmtRdata; // Inverted every cycle except on a read ack or while module reset is low
      if (!module_reset_n) begin
         flags <= 8'h00;
         evtCnt <= 6'h14; // Management init time
         done <= 1'b0;
         dly <= 2'h0;
         cfgErr <= 8'h00;
         mgmtRdata <= 8'h00;
      end else begin
         if (evtCnt == 6'h01 && !mute)
            flags <= 8'h01;
         if (evtCnt != 6'h00)
            evtCnt <= evtCnt - 6'h01;
         if (!mgmtReq) begin
            done <= 1'b0;
            dly <= 2'h0;
         end else if (!done && slow && dly != 2'h3) begin
            dly <= dly + 2'h1;
         end else if (!done) begin
            mgmtAck <= 1'b1;
            done <= 1'b1;
            if (mgmtWrite) begin
               case ({mgmtPage, mgmtAddr})
                  {PAGE_LOWER, OFS_GLOBAL_CTRL}: if (mgmtWdata[FORCE_LP_BIT]) evtCnt <= 6'h1e;
                  {PAGE_PATH, OFS_APP_SELECT}: appSel <= mgmtWdata;
                  {PAGE_PATH, OFS_APPLY_SET0}: cfgErr <= (appSel[7:4] == BAD_APP) ? 8'h01 : 8'h00;
                  {PAGE_PATH, OFS_PATH_POWER}: evtCnt <= 6'h1e;
                  default: ;
               endcase
            end else begin
               case ({mgmtPage, mgmtAddr})
                  {PAGE_LOWER, OFS_LATCHED_FLAGS}: begin
                     mgmtRdata <= flags;
                     flags <= (evtCnt == 6'h01 && !mute) ? 8'h01 : 8'h00;
                  end
                  {PAGE_LOWER, OFS_ADV_APP}: mgmtRdata <= ADV_APP;
                  {PAGE_LOWER, OFS_ADV_TIMEOUT}: mgmtRdata <= ADV_TMO;
                  {PAGE_STATUS, OFS_CFG_ERROR}: mgmtRdata <= cfgErr;
                  default: mgmtRdata <= 8'h00;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/mps_host_seq_bench.sv
// Self-checking bench for the host sequencer against a behavioural module.
// Assumes the sequencer waits are shortened to two hundred cycles.
`timescale 1ns/1ps
`default_nettype none
module mps_host_seq_bench import mps_pkg::*;;
   localparam logic [7:0] ADV_APP = 8'h5a;
   localparam logic [7:0] ADV_TMO = 8'h3c;
   localparam logic [3:0] BAD_APP = 4'hf;
   logic clk, rst_n, enable, cmdPowerUp, cmdPowerDown, cmdLowPower, presence_n, slow, mute;
   logic busy, pathsActive, lowPower, cfgError, timedOut, module_reset_n, init_select;
   logic interrupt_n, mgmtReq, mgmtWrite, mgmtAck;
   logic [3:0] appCode;
   logic [7:0] laneMask, advApps, advTimeout, lastFlags, hostTxLanesEn;
   logic [7:0] mgmtPage, mgmtAddr, mgmtWdata, mgmtRdata;
   logic [24:0] seen[$];
   logic [24:0] expq[$];
   int n_fail = 0;
   int samples_checked = 0;
   // Design and module model
   mps_host_seq #(.INIT_WAIT(200), .EVT_WAIT(200)) dut (.clk, .rst_n, .enable, .cmdPowerUp,
      .cmdPowerDown, .cmdLowPower, .appCode, .laneMask, .busy, .pathsActive, .lowPower,
      .cfgError, .timedOut, .advApps, .advTimeout, .lastFlags, .hostTxLanesEn,
      .module_reset_n, .init_select, .interrupt_n, .presence_n, .mgmtReq, .mgmtWrite,
      .mgmtPage, .mgmtAddr, .mgmtWdata, .mgmtAck, .mgmtRdata);
   mps_module_model #(.ADV_APP(ADV_APP), .ADV_TMO(ADV_TMO), .BAD_APP(BAD_APP)) model (.clk,
      .module_reset_n, .interrupt_n, .slow, .mute, .mgmtReq, .mgmtWrite, .mgmtPage,
      .mgmtAddr, .mgmtWdata, .mgmtAck, .mgmtRdata);
   // Logs every completed access
   always @(posedge clk) begin
      if (mgmtReq && mgmtAck)
         seen.push_back({mgmtWrite, mgmtPage, mgmtAddr, mgmtWrite ? mgmtWdata : 8'h00});
   end
   function automatic logic [24:0] e(input logic w, input logic [7:0] p, a, d);
      return {w, p, a, d};
   endfunction
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_log();
      cmp(seen.size(), expq.size());
      foreach (expq[i]) if (i < seen.size()) cmp(seen[i], expq[i]);
      seen.delete();
   endtask
   // Waits for n accesses and an idle sequencer
   task automatic wait_done(input int n);
      int k;
      k = 0;
      while (seen.size() < n || busy !== 1'b0) begin
         @(negedge clk);
         k++;
         if (k > 5000) begin
            n_fail++;
            report_and_stop();
         end
      end
   endtask
   task automatic pulse(input int c, input int n);
      @(negedge clk);
      cmdPowerUp = (c == 0);
      cmdPowerDown = (c == 1);
      cmdLowPower = (c == 2);
      @(negedge clk);
      {cmdPowerUp, cmdPowerDown, cmdLowPower} = 3'b000;
      wait_done(n);
   endtask
   task automatic bring_up(input logic quiet);
      mute = quiet;
      @(negedge clk);
      enable = 1'b1;
      presence_n = 1'b0;
      wait_done(3);
      expq = '{e(0, PAGE_LOWER, OFS_LATCHED_FLAGS, 0), e(0, PAGE_LOWER, OFS_ADV_APP, 0),
               e(0, PAGE_LOWER, OFS_ADV_TIMEOUT, 0)};
      check_log();
      cmp({advApps, advTimeout}, {ADV_APP, ADV_TMO});
      cmp({lastFlags, timedOut, lowPower}, {quiet ? 8'h00 : 8'h01, quiet, 1'b1});
   endtask
   task automatic power_up(input logic [3:0] app, input logic [7:0] lanes);
      appCode = app;
      laneMask = lanes;
      slow = 1'b1;
      expq = '{e(1, PAGE_LOWER, OFS_GLOBAL_CTRL, GLOBAL_RUN), e(1, PAGE_PATH, OFS_APP_SELECT,
               {app, 4'h0}), e(1, PAGE_PATH, OFS_APPLY_SET0, lanes), e(0, PAGE_STATUS,
               OFS_CFG_ERROR, 0)};
      if (app == BAD_APP) begin
         pulse(0, 4);
         check_log();
         cmp({cfgError, lowPower, pathsActive}, 3'b110);
      end else begin
         expq.push_back(e(1, PAGE_PATH, OFS_TX_DISABLE, ALL_LANES));
         expq.push_back(e(1, PAGE_PATH, OFS_PATH_POWER, lanes));
         expq.push_back(e(0, PAGE_LOWER, OFS_LATCHED_FLAGS, 0));
         expq.push_back(e(1, PAGE_PATH, OFS_TX_DISABLE, ~lanes));
         pulse(0, 8);
         check_log();
         cmp({hostTxLanesEn, lastFlags}, {lanes, 8'h01});
         cmp({cfgError, pathsActive}, 2'b01);
      end
      slow = 1'b0;
   endtask
   task automatic power_down();
      pulse(1, 2);
      expq = '{e(1, PAGE_PATH, OFS_PATH_POWER, NO_LANES), e(0, PAGE_LOWER, OFS_LATCHED_FLAGS, 0)};
      check_log();
      cmp({hostTxLanesEn, lastFlags, pathsActive}, {8'h00, 8'h01, 1'b0});
   endtask
   task automatic low_power();
      pulse(2, 2);
      expq = '{e(1, PAGE_LOWER, OFS_GLOBAL_CTRL, FORCE_LP_SET), e(0, PAGE_LOWER,
               OFS_LATCHED_FLAGS, 0)};
      check_log();
      cmp({lowPower, lastFlags}, {1'b1, 8'h01});
   endtask
   task automatic drop_presence();
      @(negedge clk);
      presence_n = 1'b1;
      repeat (2) @(negedge clk);
      cmp({module_reset_n, hostTxLanesEn, pathsActive}, 10'h000);
      seen.delete();
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {enable, cmdPowerUp, cmdPowerDown, cmdLowPower, slow, mute} = 6'h00;
      presence_n = 1'b1;
      appCode = 4'h0;
      laneMask = 8'h00;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      cmp({module_reset_n, init_select}, 2'b01);
      bring_up(1'b0);
      power_up(BAD_APP, 8'h0f);
      power_up(4'h3, 8'h0f);
      power_down();
      low_power();
      power_up(4'h6, 8'hff);
      drop_presence();
      bring_up(1'b1);
      report_and_stop();
   end
endmodule
bind mps_host_seq mps_host_seq_asserts chk (.clk, .rst_n, .enable, .pathsActive, .lowPower,
   .cfgError, .timedOut, .hostTxLanesEn, .module_reset_n, .init_select, .interrupt_n,
   .presence_n, .mgmtReq, .mgmtWrite, .mgmtPage, .mgmtAddr, .mgmtWdata, .mgmtAck);
`default_nettype wire
